// ---- rtl/ssb_pkg.sv ----
package ssb_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [4:0] OFF_STATUS    = 5'h00;
    localparam logic [4:0] OFF_DIVISOR   = 5'h04;
    localparam logic [4:0] OFF_MODE      = 5'h08;
    localparam logic [4:0] OFF_CONTROL   = 5'h0c;
    localparam logic [4:0] OFF_TX_HOLD   = 5'h10;
    localparam logic [4:0] OFF_RX_HOLD   = 5'h14;
    localparam logic [4:0] OFF_IRQ_STAT  = 5'h18;
    localparam logic [4:0] OFF_IRQ_MASK  = 5'h1c;

    // ----------------------------------------------------------------
    // Status bit positions
    // ----------------------------------------------------------------
    localparam int BIT_TX_EMPTY  = 7;
    localparam int BIT_RX_FULL   = 6;
    localparam int BIT_PARITY    = 3;
    localparam int BIT_TX_END    = 2;
    localparam int BIT_MP_RX     = 1;
    localparam int BIT_MP_TX     = 0;

    // Interrupt status and mask bit positions.
    localparam int IRQ_RX_FULL   = 0;
    localparam int IRQ_TX_EMPTY  = 1;
    localparam int IRQ_TX_END    = 2;
    localparam int IRQ_PARITY    = 3;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] DIVISOR_RESET  = 8'hff;
    localparam logic [3:0] ASYNC_BIT_LAST = 4'hf;  // 16 sample ticks per bit.
    localparam logic [3:0] SYNC_BIT_LAST  = 4'h1;  // 2 sample ticks per bit.
    localparam logic [3:0] ASYNC_MID      = 4'h7;
    localparam logic [3:0] SYNC_BITS      = 4'h8;

    typedef struct packed {
        logic       sync_mode;
        logic       parity_en;
        logic       parity_odd_select;
        logic       mp_en;
        logic       clock_select_hi;
        logic       clock_select_lo;
    } ssb_mode_type;

    typedef struct packed {
        logic receiver_enable_bit;
        logic transmitter_enable_bit;
    } ssb_control_type;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } ssb_state_type;

endpackage : ssb_pkg

// ---- rtl/ssb_serial.sv ----
// Behaviour
// - Parity error sets when ones in data plus parity mismatch odd/even select.
// - Parity error clears only by writing 0 after reading it as 1.
// - Receiver disabled leaves the parity error flag unchanged.
// - Parity error still loads rx holding register but leaves rx full clear.
// - Parity error blocks reception; in synchronous mode blocks all transfers.
// - Transmit end is read-only bit 2, resets to 1.
// - Transmit end clears on tx empty software clear or tx holding write.
// - Transmit end sets when transmitter disabled or last bit sent with empty.
// - Async multiprocessor format captures received mp bit into read-only bit 1.
// - Receiver disabled keeps the captured mp bit unchanged.
// - Writable bit 0 is sent as mp bit of each async multiprocessor character.
// - Mp transmit bit ignored in sync mode, mp disabled or tx disabled.
// - Eight-bit divisor with prescaled clock sets both tx and rx bit rate.
// - Divisor register readable and writable at any time.
// - Divisor loads all ones on reset and on low-power mode entry.
// - Async bit rate is clock over 64, over 4 to the n, over divisor plus one.
// - Clock select picks clock, clock/4, clock/16 or clock/64.
`timescale 1ns/1ps
`default_nettype none

module ssb_serial
    import ssb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        low_power_entry,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        rxd,
    output logic             txd,
    output logic             sck_out,
    output logic             irq
);

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    logic [7:0]       bit_rate_divisor;
    ssb_mode_type     serial_mode_reg;
    ssb_control_type  serial_control_reg;
    logic [7:0]       tx_holding_reg;
    logic [7:0]       rx_holding_reg;
    logic             tx_buffer_empty_flag;
    logic             rx_full_flag;
    logic             parity_error_flag;
    logic             transmit_end_flag;
    logic             mp_bit_received;
    logic             mp_bit_to_send;
    logic             seen_tx_empty;
    logic             seen_rx_full;
    logic             seen_parity;
    logic [3:0]       irq_status;
    logic [3:0]       irq_mask;

    logic [5:0]       pre_cnt;
    logic [7:0]       div_cnt;
    logic [1:0]       quad_cnt;
    logic             pre_tick;
    logic             base_tick;
    logic             samp_tick;

    ssb_state_type    tx_state;
    logic [10:0]      tx_sh;
    logic [3:0]       tx_left;
    logic [3:0]       tx_phase;
    logic             tx_has_char;
    logic             frame_rx;
    logic [7:0]       sync_rx_sh;

    ssb_state_type    rx_state;
    logic [3:0]       rx_phase;
    logic [3:0]       rx_cnt;
    logic [9:0]       rx_sh;
    logic             rxd_q;

    logic             bus_wr;
    logic             bus_rd;
    logic             wr_b0;
    logic             te;
    logic             re;
    logic             sync;
    logic             extra_en;
    logic [3:0]       bit_last;
    logic             tx_load;
    logic             tx_start;
    logic             tx_bit_end;
    logic             tx_last;
    logic             async_done;
    logic             sync_done;
    logic             rx_done;
    logic [7:0]       rx_byte;
    logic             rx_extra;
    logic             parity_bad;
    logic             sw_clr_tx_empty;
    logic             sw_clr_rx_full;
    logic             sw_clr_parity;
    logic             tx_hold_wr;
    logic             rx_hold_rd;
    logic [31:0]      next_readdata;
    logic [3:0]       irq_events;

    assign te       = serial_control_reg.transmitter_enable_bit;
    assign re       = serial_control_reg.receiver_enable_bit;
    assign sync     = serial_mode_reg.sync_mode;
    assign extra_en = serial_mode_reg.parity_en | serial_mode_reg.mp_en;
    assign bit_last = sync ? SYNC_BIT_LAST : ASYNC_BIT_LAST;

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then the access completes
    // ----------------------------------------------------------------
    // The answer is prepared while waitrequest is high, so readdata is a
    // flip-flop and every side effect lands on the completing edge only.
    assign bus_wr = write && !waitrequest;
    assign bus_rd = read && !waitrequest;
    assign wr_b0  = bus_wr && byteenable[0];

    always_comb begin
        next_readdata = 32'h0000_0000;
        if (address == OFF_STATUS) begin
            next_readdata[BIT_TX_EMPTY] = tx_buffer_empty_flag;
            next_readdata[BIT_RX_FULL]  = rx_full_flag;
            next_readdata[BIT_PARITY]   = parity_error_flag;
            next_readdata[BIT_TX_END]   = transmit_end_flag;
            next_readdata[BIT_MP_RX]    = mp_bit_received;
            next_readdata[BIT_MP_TX]    = mp_bit_to_send;
        end else if (address == OFF_DIVISOR) begin
            next_readdata[7:0] = bit_rate_divisor;
        end else if (address == OFF_MODE) begin
            next_readdata[5:0] = serial_mode_reg;
        end else if (address == OFF_CONTROL) begin
            next_readdata[1:0] = serial_control_reg;
        end else if (address == OFF_TX_HOLD) begin
            next_readdata[7:0] = tx_holding_reg;
        end else if (address == OFF_RX_HOLD) begin
            next_readdata[7:0] = rx_holding_reg;
        end else if (address == OFF_IRQ_STAT) begin
            next_readdata[3:0] = irq_status;
        end else if (address == OFF_IRQ_MASK) begin
            next_readdata[3:0] = irq_mask;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else if (ce) begin
            if ((read || write) && waitrequest) begin
                waitrequest <= 1'b0;
                readdata    <= next_readdata;
            end else begin
                waitrequest <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Software-owned registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_rate_divisor <= DIVISOR_RESET;
        end else if (ce) begin
            if (low_power_entry) begin
                bit_rate_divisor <= DIVISOR_RESET;
            end else if (wr_b0 && address == OFF_DIVISOR) begin
                bit_rate_divisor <= writedata[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_mode_reg    <= '0;
            serial_control_reg <= '0;
            irq_mask           <= 4'h0;
            mp_bit_to_send     <= 1'b0;
            tx_holding_reg     <= 8'h00;
        end else if (ce && wr_b0) begin
            if (address == OFF_MODE) begin
                serial_mode_reg <= writedata[5:0];
            end else if (address == OFF_CONTROL) begin
                serial_control_reg <= writedata[1:0];
            end else if (address == OFF_IRQ_MASK) begin
                irq_mask <= writedata[3:0];
            end else if (address == OFF_STATUS) begin
                mp_bit_to_send <= writedata[BIT_MP_TX];
            end else if (address == OFF_TX_HOLD) begin
                tx_holding_reg <= writedata[7:0];
            end
        end
    end

    // A clear by writing 0 is honoured only after the same flag was read
    // as 1, so a late write cannot wipe an event software never saw.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_tx_empty <= 1'b0;
            seen_rx_full  <= 1'b0;
            seen_parity   <= 1'b0;
        end else if (ce) begin
            if (bus_rd && address == OFF_STATUS) begin
                seen_tx_empty <= readdata[BIT_TX_EMPTY];
                seen_rx_full  <= readdata[BIT_RX_FULL];
                seen_parity   <= readdata[BIT_PARITY];
            end else if (wr_b0 && address == OFF_STATUS) begin
                seen_tx_empty <= 1'b0;
                seen_rx_full  <= 1'b0;
                seen_parity   <= 1'b0;
            end
        end
    end

    assign sw_clr_tx_empty = wr_b0 && address == OFF_STATUS && seen_tx_empty
                             && !writedata[BIT_TX_EMPTY];
    assign sw_clr_rx_full  = wr_b0 && address == OFF_STATUS && seen_rx_full
                             && !writedata[BIT_RX_FULL];
    assign sw_clr_parity   = wr_b0 && address == OFF_STATUS && seen_parity
                             && !writedata[BIT_PARITY];
    assign tx_hold_wr      = wr_b0 && address == OFF_TX_HOLD;
    assign rx_hold_rd      = bus_rd && address == OFF_RX_HOLD;

    // ----------------------------------------------------------------
    // Baud rate generator
    // ----------------------------------------------------------------
    always_comb begin
        case ({serial_mode_reg.clock_select_hi, serial_mode_reg.clock_select_lo})
            2'h0:    pre_tick = 1'b1;
            2'h1:    pre_tick = (pre_cnt[1:0] == 2'h3);
            2'h2:    pre_tick = (pre_cnt[3:0] == 4'hf);
            default: pre_tick = (pre_cnt == 6'h3f);
        endcase
    end

    // The >= compare lets a smaller divisor take effect at once instead of
    // waiting for the counter to wrap through 255.
    assign base_tick = pre_tick && (div_cnt >= bit_rate_divisor);
    assign samp_tick = base_tick && (quad_cnt == 2'h3);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_cnt  <= 6'h00;
            div_cnt  <= 8'h00;
            quad_cnt <= 2'h0;
        end else if (ce) begin
            pre_cnt <= pre_cnt + 6'h01;
            if (base_tick) begin
                div_cnt  <= 8'h00;
                quad_cnt <= quad_cnt + 2'h1;
            end else if (pre_tick) begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Transmit engine (also clocks synchronous frames)
    // ----------------------------------------------------------------
    assign tx_load    = samp_tick && tx_state == ST_IDLE && te && !tx_buffer_empty_flag
                        && !(sync && parity_error_flag);
    assign tx_start   = tx_load || (samp_tick && tx_state == ST_IDLE && sync && re && !te
                        && !rx_full_flag && !parity_error_flag);
    assign tx_bit_end = samp_tick && tx_state == ST_RUN && tx_phase == bit_last;
    assign tx_last    = tx_bit_end && tx_left == 4'h1;
    assign sync_done  = tx_last && sync && frame_rx;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_state    <= ST_IDLE;
            tx_sh       <= 11'h7ff;
            tx_left     <= 4'h0;
            tx_phase    <= 4'h0;
            tx_has_char <= 1'b0;
            frame_rx    <= 1'b0;
        end else if (ce) begin
            if (tx_start) begin
                tx_state    <= ST_RUN;
                tx_phase    <= 4'h0;
                tx_has_char <= tx_load;
                frame_rx    <= sync && re;
                if (sync) begin
                    tx_sh   <= {3'h7, tx_load ? tx_holding_reg : 8'hff};
                    tx_left <= SYNC_BITS;
                end else if (serial_mode_reg.mp_en) begin
                    tx_sh   <= {1'b1, mp_bit_to_send, tx_holding_reg, 1'b0};
                    tx_left <= 4'hb;
                end else if (serial_mode_reg.parity_en) begin
                    tx_sh   <= {1'b1, ^tx_holding_reg ^ serial_mode_reg.parity_odd_select,
                                tx_holding_reg, 1'b0};
                    tx_left <= 4'hb;
                end else begin
                    tx_sh   <= {2'h3, tx_holding_reg, 1'b0};
                    tx_left <= 4'ha;
                end
            end else if (samp_tick && tx_state == ST_RUN) begin
                tx_phase <= tx_bit_end ? 4'h0 : tx_phase + 4'h1;
                if (tx_bit_end) begin
                    tx_sh   <= {1'b1, tx_sh[10:1]};
                    tx_left <= tx_left - 4'h1;
                    if (tx_last) begin
                        tx_state <= ST_IDLE;
                    end
                end
            end
        end
    end

    // Synchronous receive samples on the rising serial clock edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_rx_sh <= 8'h00;
        end else if (ce && samp_tick && tx_state == ST_RUN && sync && tx_phase == 4'h0) begin
            sync_rx_sh <= {rxd, sync_rx_sh[7:1]};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txd     <= 1'b1;
            sck_out <= 1'b1;
        end else if (ce) begin
            txd     <= (tx_state == ST_RUN) ? tx_sh[0] : 1'b1;
            sck_out <= !(tx_state == ST_RUN && sync && tx_phase == 4'h0);
        end
    end

    // ----------------------------------------------------------------
    // Asynchronous receive engine
    // ----------------------------------------------------------------
    assign async_done = samp_tick && rx_state == ST_RUN && rx_phase == ASYNC_MID
                        && rx_cnt == (extra_en ? 4'ha : 4'h9);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_state <= ST_IDLE;
            rx_phase <= 4'h0;
            rx_cnt   <= 4'h0;
            rx_sh    <= 10'h000;
            rxd_q    <= 1'b1;
        end else if (ce && samp_tick) begin
            rxd_q <= rxd;
            if (rx_state == ST_IDLE) begin
                if (re && !sync && !parity_error_flag && rxd_q && !rxd) begin
                    rx_state <= ST_RUN;
                    rx_phase <= 4'h0;
                    rx_cnt   <= 4'h0;
                    rx_sh    <= 10'h000;
                end
            end else if (!re || sync) begin
                rx_state <= ST_IDLE;
            end else begin
                rx_phase <= rx_phase + 4'h1;
                if (rx_phase == ASYNC_MID) begin
                    if (rx_cnt == 4'h0 && rxd) begin
                        rx_state <= ST_IDLE;
                    end else begin
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_cnt != 4'h0) begin
                            rx_sh <= {rxd, rx_sh[9:1]};
                        end
                        if (async_done) begin
                            rx_state <= ST_IDLE;
                        end
                    end
                end
            end
        end
    end

    // While the stop bit is sampled, before it shifts in, data sits low when an extra bit
    // is present and one place higher when it is not.
    assign rx_done    = (async_done || sync_done) && re;
    assign rx_byte    = sync_done ? sync_rx_sh : (extra_en ? rx_sh[8:1] : rx_sh[9:2]);
    assign rx_extra   = rx_sh[9];
    assign parity_bad = async_done && serial_mode_reg.parity_en && !serial_mode_reg.mp_en
                        && ((^rx_byte ^ rx_extra) != serial_mode_reg.parity_odd_select);

    // ----------------------------------------------------------------
    // Status flags (a hardware set always wins over a clear)
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_holding_reg    <= 8'h00;
            rx_full_flag      <= 1'b0;
            parity_error_flag <= 1'b0;
            mp_bit_received   <= 1'b0;
        end else if (ce) begin
            if (rx_done) begin
                rx_holding_reg <= rx_byte;
            end
            if (rx_done && !parity_bad) begin
                rx_full_flag <= 1'b1;
            end else if (sw_clr_rx_full || rx_hold_rd) begin
                rx_full_flag <= 1'b0;
            end
            // Only reception ever sets the flag, so a disabled receiver
            // leaves it exactly as it was.
            if (rx_done && parity_bad) begin
                parity_error_flag <= 1'b1;
            end else if (sw_clr_parity) begin
                parity_error_flag <= 1'b0;
            end
            if (async_done && re && serial_mode_reg.mp_en) begin
                mp_bit_received <= rx_extra;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_buffer_empty_flag <= 1'b1;
            transmit_end_flag    <= 1'b1;
        end else if (ce) begin
            if (!te || tx_load) begin
                tx_buffer_empty_flag <= 1'b1;
            end else if (sw_clr_tx_empty || tx_hold_wr) begin
                tx_buffer_empty_flag <= 1'b0;
            end
            if (!te || (tx_last && tx_has_char && tx_buffer_empty_flag)) begin
                transmit_end_flag <= 1'b1;
            end else if (sw_clr_tx_empty || tx_hold_wr) begin
                transmit_end_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign irq_events[IRQ_RX_FULL]  = rx_done && !parity_bad;
    assign irq_events[IRQ_TX_EMPTY] = tx_load;
    assign irq_events[IRQ_TX_END]   = tx_last && tx_has_char && tx_buffer_empty_flag;
    assign irq_events[IRQ_PARITY]   = rx_done && parity_bad;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= 4'h0;
            irq        <= 1'b0;
        end else if (ce) begin
            if (wr_b0 && address == OFF_IRQ_STAT) begin
                irq_status <= (irq_status & ~writedata[3:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule : ssb_serial

`default_nettype wire

// ---- testbench/ssb_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------
// Checks
// ------
module ssb_checker import ssb_pkg::*; (
    input wire logic        clk, arst_n, ce, low_power_entry, read, write,
    input wire logic [4:0]  address,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] writedata, readdata,
    input wire logic        waitrequest, rxd, txd, sck_out, irq
);
    logic [7:0] div_m;
    wire logic  take = (read || write) && waitrequest && ce;
    // Divisor shadow; a write lands only at the edge that completes it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) div_m <= DIVISOR_RESET;
        else if (ce && low_power_entry) div_m <= DIVISOR_RESET;
        else if (write && !waitrequest && ce && address == OFF_DIVISOR && byteenable[0])
            div_m <= writedata[7:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_answer; take |=> !waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_release; !waitrequest && ce |=> waitrequest; endproperty
    a_release: assert property (p_release) else $error("answer held too long");
    property p_upper; !waitrequest |-> readdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_div; take && read && address == OFF_DIVISOR |=> readdata[7:0] == div_m; endproperty
    a_div: assert property (p_div) else $error("divisor read wrong");
    property p_lowpow;
        take && read && address == OFF_DIVISOR && low_power_entry && $past(low_power_entry && ce)
        |=> readdata[7:0] == 8'hff;
    endproperty
    a_lowpow: assert property (p_lowpow) else $error("divisor not all ones");
    property p_freeze; !ce |=> $stable(txd) && $stable(waitrequest) && $stable(readdata); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while stalled");
    property p_idle; $rose(arst_n) |-> waitrequest && txd && sck_out && !irq; endproperty
    a_idle: assert property (p_idle) else $error("outputs not idle after reset");
    property p_bit; $fell(txd) |-> !txd [*8]; endproperty
    a_bit: assert property (p_bit) else $error("line bit too short");
endmodule : ssb_checker
bind ssb_serial ssb_checker i_chk (.clk(clk), .arst_n(arst_n), .ce(ce),
    .low_power_entry(low_power_entry), .read(read), .write(write), .address(address),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxd(rxd), .txd(txd), .sck_out(sck_out), .irq(irq));
`default_nettype wire

// ---- testbench/ssb_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------
// Remote
// ------
module ssb_remote (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'b1;
    // Bits last 64 clocks, so the divisor must be 0 and the prescaler 00.
    task automatic send(input logic [8:0] f);
        for (int i = 0; i < 11; i++) begin
            rxd <= i == 0 ? 1'b0 : i == 10 ? 1'b1 : f[i-1];
            repeat (64) @(posedge clk);
        end
    endtask : send
    task automatic recv(output logic [8:0] f, output logic ok);
        ok = 1'b0;
        f = 9'h0;
        for (int t = 0; t < 3000 && !ok; t++) begin
            @(posedge clk);
            ok = !txd;
        end
        repeat (32) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (64) @(posedge clk);
            f[i] = txd;
        end
    endtask : recv
endmodule : ssb_remote
`default_nettype wire

// ---- testbench/ssb_serial_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// -----
// Bench
// -----
module ssb_serial_test import ssb_pkg::*;;
    logic        clk, arst_n, ce, lp, read, write, txd, sck_out, irq, waitrequest, rxd, ok;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rd;
    logic [8:0]  fr;
    int          error_cnt, n_checks;
    ssb_serial i_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .low_power_entry(lp),
        .address(address), .read(read), .write(write), .byteenable(4'h1),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .rxd(rxd), .txd(txd), .sck_out(sck_out), .irq(irq));
    ssb_remote i_rem (.clk(clk), .txd(txd), .rxd(rxd));
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One Avalon transfer; request held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        writedata <= {24'h0, d};
        read <= !wr;
        write <= wr;
        for (int t = 0; t < 50; t++) begin
            @(posedge clk);
            if (!waitrequest) begin
                rd = readdata;
                read <= 1'b0;
                write <= 1'b0;
                return;
            end
        end
        error_cnt++;
        report_and_stop();
    endtask : bus
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h0);
        chk(rd, e);
    endtask : rdc
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {arst_n, read, write, lp, address, writedata} = '0;
        ce = 1'b1;
        error_cnt = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rdc(OFF_DIVISOR, 32'hff);
        rdc(OFF_STATUS, 32'h84);
        bus(1'b1, OFF_STATUS, 8'h81);
        rdc(OFF_STATUS, 32'h85);
        bus(1'b1, OFF_DIVISOR, 8'h00);
        rdc(OFF_DIVISOR, 32'h0);
        lp <= 1'b1;
        rdc(OFF_DIVISOR, 32'hff);
        lp <= 1'b0;
        rdc(OFF_DIVISOR, 32'hff);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        rdc(5'h1e, 32'h0);
        bus(1'b1, OFF_DIVISOR, 8'h00);
        bus(1'b1, OFF_MODE, 8'h10);
        bus(1'b1, OFF_CONTROL, 8'h02);
        i_rem.send(9'h103);
        rdc(OFF_STATUS, 32'h8d);
        rdc(OFF_RX_HOLD, 32'h03);
        i_rem.send(9'h005);
        rdc(OFF_RX_HOLD, 32'h03);
        bus(1'b1, OFF_IRQ_MASK, 8'h08);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, OFF_IRQ_STAT, 8'h08);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, OFF_CONTROL, 8'h00);
        rdc(OFF_STATUS, 32'h8d);
        bus(1'b1, OFF_STATUS, 8'h89);
        bus(1'b1, OFF_STATUS, 8'h81);
        rdc(OFF_STATUS, 32'h8d);
        bus(1'b1, OFF_STATUS, 8'h81);
        rdc(OFF_STATUS, 32'h85);
        bus(1'b1, OFF_MODE, 8'h04);
        bus(1'b1, OFF_CONTROL, 8'h03);
        i_rem.send(9'h15a);
        rdc(OFF_STATUS, 32'hc7);
        rdc(OFF_RX_HOLD, 32'h5a);
        bus(1'b1, OFF_CONTROL, 8'h01);
        rdc(OFF_STATUS, 32'h87);
        bus(1'b1, OFF_TX_HOLD, 8'ha5);
        bus(1'b0, OFF_STATUS, 8'h0);
        chk(rd & 32'h4, 32'h0);
        i_rem.recv(fr, ok);
        chk({22'h0, ok, fr}, {22'h0, 1'b1, 9'h1a5});
        repeat (150) @(posedge clk);
        rdc(OFF_STATUS, 32'h87);
        bus(1'b1, OFF_MODE, 8'h20);
        bus(1'b1, OFF_TX_HOLD, 8'h3c);
        for (int t = 0; t < 99 && sck_out; t++) @(posedge clk);
        chk({31'h0, sck_out}, 32'h0);
        report_and_stop();
    end
endmodule : ssb_serial_test
`default_nettype wire
